// File: hw/fpgc_pkg.sv
/*
  fpgc_pkg: offsets, field positions, reset values and carrier types for
  the four-pin general-purpose port block.
  assumes: a single 50 MHz host clock and a plain register port.
*/
package fpgc_pkg;

  // ==========================================================================
  // register map
  localparam logic [7:0] FPGC_GENERAL_PIN_CONTROL_OFF = 8'hfc;
  localparam logic [31:0] FPGC_CTRL_RESET = 32'h00001010;
  // writable bits; everything else is reserved and reads as zero
  localparam logic [31:0] FPGC_CTRL_WMASK = 32'h3131b1b1;

  // ==========================================================================
  // field positions
  localparam int FPGC_PIN0_DATA = 0;
  localparam int FPGC_PIN0_OUTPUT_ENABLE = 4;
  localparam int FPGC_PIN0_INVERT = 5;
  localparam int FPGC_PIN0_GENERAL_PURPOSE_SELECT = 7;
  localparam int FPGC_PIN1_DATA = 8;
  localparam int FPGC_PIN1_OUTPUT_ENABLE = 12;
  localparam int FPGC_PIN1_INVERT = 13;
  localparam int FPGC_PIN1_GENERAL_PURPOSE_SELECT = 15;
  localparam int FPGC_PIN2_DATA = 16;
  localparam int FPGC_PIN2_OUTPUT_ENABLE = 20;
  localparam int FPGC_PIN2_INVERT = 21;
  localparam int FPGC_PIN3_DATA = 24;
  localparam int FPGC_PIN3_OUTPUT_ENABLE = 28;
  localparam int FPGC_PIN3_INVERT = 29;
  localparam int FPGC_PINS = 4;

  // ==========================================================================
  // carrier types
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } fpgc_req_s;

  // per-pin configuration picked out of the control word
  typedef struct packed {
    logic gp_sel;
    logic invert;
    logic oe;
    logic data;
  } fpgc_pin_cfg_s;

  // drive level and enable of one two-way terminal
  typedef struct packed {
    logic out;
    logic oe;
  } fpgc_pad_s;

endpackage

// File: hw/fpgc_sync.sv
/*
  fpgc_sync: two-flop synchroniser for the four terminal input levels.
  assumes: inputs may change at any time relative to clk_i.
*/
`timescale 1ns/1ns
`default_nettype none

module fpgc_sync (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] async_i,
  output logic [3:0] sync_o
);

  // ==========================================================================
  // synchroniser; the first stage feeds only the second
  logic [3:0] meta_r;
  logic [3:0] sync_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= 4'h0;
      sync_r <= 4'h0;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;

endmodule // fpgc_sync

`default_nettype wire

// File: hw/fpgc_pin.sv
/*
  fpgc_pin: output mux and polarity for one terminal.
  assumes: link_* are tied low by the parent for pins without a link
  function, with gp_sel held high.
*/
`timescale 1ns/1ns
`default_nettype none

module fpgc_pin (
  input wire fpgc_pkg::fpgc_pin_cfg_s cfg_i,
  input wire logic link_out_i,
  input wire logic link_oe_i,
  input wire logic pad_sync_i,
  output var fpgc_pkg::fpgc_pad_s pad_o,
  output logic gp_level_o
);

  // ==========================================================================
  // drive selection
  wire logic gp_out;
  wire logic gp_oe;

  // polarity applies to the driven level
  assign gp_out = cfg_i.data ^ cfg_i.invert;
  assign gp_oe = cfg_i.oe;
  // link function owns the terminal until selected
  assign pad_o.out = cfg_i.gp_sel ? gp_out : link_out_i;
  assign pad_o.oe = cfg_i.gp_sel ? gp_oe : link_oe_i;
  // sampled level through the same inversion
  assign gp_level_o = pad_sync_i ^ (cfg_i.gp_sel & cfg_i.invert);

endmodule // fpgc_pin

`default_nettype wire

// File: hw/fpgc_top.sv
/*
  fpgc_top: four-pin general-purpose port with one 32-bit control
  register. pins 0 and 1 share terminals with the bus manager contender
  and link power status outputs of the link; pins 2 and 3 are always
  general purpose. the data bit of a pin that general-purpose logic does
  not drive reads back the synchronised terminal level, through the inversion only while selected.
  assumes: register port strobes are one cycle long and synchronous;
  read data are wanted in the cycle after the read strobe only;
  terminal inputs are synchronised here, so a level change reaches the
  read path two edges late; the link levels are already synchronous to
  clk_i and go to the terminals without a register stage; software
  that polls a terminal must allow for the synchroniser delay.
*/
// Design decision made here: the address-and-strobe port.
// Overview of operation
// - terminal 0 is contender until select bit set
// - terminal 1 is power status until select set
// - reserved bits read zero, ignore writes
// - pin3 invert sets in and out polarity
// - pin3 enable gates driver, reset off
// - pin3 drives its data bit when enabled
// - pin2 invert sets in and out polarity
// - pin2 enable gates driver, reset off
// - pin2 drives its data bit when enabled
// - pin1 invert acts only when selected
// - pin1 enable acts when selected, resets one
// - pin1 drives data when selected and enabled
// - pin0 invert acts only when selected
// - pin0 enable acts when selected, resets one
// - pin0 drives data when selected and enabled
`timescale 1ns/1ns
`default_nettype none

module fpgc_top (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic bus_manager_contender_pin_i,
  input wire logic link_power_status_pin_i,
  input wire logic [3:0] pin_in_i,
  output logic [3:0] pin_out_o,
  output logic [3:0] pin_oe_o
);

  // ==========================================================================
  // request decode
  fpgc_pkg::fpgc_req_s req;
  wire logic sel_ctrl;
  wire logic wr_ctrl;
  wire logic rd_ctrl;
  wire logic [31:0] wr_word;

  assign req.addr = addr_i;
  assign req.wdata = wdata_i;
  assign req.wr = wr_i;
  assign req.rd = rd_i;
  assign sel_ctrl = (req.addr == fpgc_pkg::FPGC_GENERAL_PIN_CONTROL_OFF);
  assign wr_ctrl = req.wr & sel_ctrl;
  assign rd_ctrl = req.rd & sel_ctrl;
  // reserved positions are dropped before they reach the register
  assign wr_word = req.wdata & fpgc_pkg::FPGC_CTRL_WMASK;

  // ==========================================================================
  // control register
  logic [31:0] ctrl_r;
  logic [31:0] ctrl_nxt;

  assign ctrl_nxt = wr_ctrl ? wr_word : ctrl_r;

  // reset value holds pin0 and pin1 enables high
  // asynchronous, so the terminals take their link roles at once
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_r <= fpgc_pkg::FPGC_CTRL_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // ==========================================================================
  // per-pin configuration
  // positions come in as ints so one function serves all four pins
  function automatic fpgc_pkg::fpgc_pin_cfg_s cfg_of(
    input logic [31:0] c,
    input logic sel,
    input int inv,
    input int oe,
    input int dat
  );
    fpgc_pkg::fpgc_pin_cfg_s r;
    r.gp_sel = sel;
    r.invert = c[inv];
    r.oe = c[oe];
    r.data = c[dat];
    return r;
  endfunction

  fpgc_pkg::fpgc_pin_cfg_s cfg [4];
  wire logic sel0;
  wire logic sel1;

  // contender output until select bit set
  assign sel0 = ctrl_r[fpgc_pkg::FPGC_PIN0_GENERAL_PURPOSE_SELECT];
  // power status output until select bit set
  assign sel1 = ctrl_r[fpgc_pkg::FPGC_PIN1_GENERAL_PURPOSE_SELECT];
  assign cfg[0] = cfg_of(
    ctrl_r,
    sel0,
    fpgc_pkg::FPGC_PIN0_INVERT,
    fpgc_pkg::FPGC_PIN0_OUTPUT_ENABLE,
    fpgc_pkg::FPGC_PIN0_DATA
  );

  assign cfg[1] = cfg_of(
    ctrl_r,
    sel1,
    fpgc_pkg::FPGC_PIN1_INVERT,
    fpgc_pkg::FPGC_PIN1_OUTPUT_ENABLE,
    fpgc_pkg::FPGC_PIN1_DATA
  );

  assign cfg[2] = cfg_of(
    ctrl_r,
    1'b1,
    fpgc_pkg::FPGC_PIN2_INVERT,
    fpgc_pkg::FPGC_PIN2_OUTPUT_ENABLE,
    fpgc_pkg::FPGC_PIN2_DATA
  );

  assign cfg[3] = cfg_of(
    ctrl_r,
    1'b1,
    fpgc_pkg::FPGC_PIN3_INVERT,
    fpgc_pkg::FPGC_PIN3_OUTPUT_ENABLE,
    fpgc_pkg::FPGC_PIN3_DATA
  );

  // ==========================================================================
  // field decode for the read path
  wire logic pin0_oe_bit;
  wire logic pin1_oe_bit;
  wire logic pin2_oe_bit;
  wire logic pin3_oe_bit;

  wire logic pin0_data_bit;
  wire logic pin1_data_bit;
  wire logic pin2_data_bit;
  wire logic pin3_data_bit;

  // enables decide whether a pin reads its terminal
  assign pin0_oe_bit = ctrl_r[fpgc_pkg::FPGC_PIN0_OUTPUT_ENABLE];
  assign pin1_oe_bit = ctrl_r[fpgc_pkg::FPGC_PIN1_OUTPUT_ENABLE];
  assign pin2_oe_bit = ctrl_r[fpgc_pkg::FPGC_PIN2_OUTPUT_ENABLE];
  assign pin3_oe_bit = ctrl_r[fpgc_pkg::FPGC_PIN3_OUTPUT_ENABLE];

  // stored data bits, shown while the pin drives
  assign pin0_data_bit = ctrl_r[fpgc_pkg::FPGC_PIN0_DATA];
  assign pin1_data_bit = ctrl_r[fpgc_pkg::FPGC_PIN1_DATA];
  assign pin2_data_bit = ctrl_r[fpgc_pkg::FPGC_PIN2_DATA];
  assign pin3_data_bit = ctrl_r[fpgc_pkg::FPGC_PIN3_DATA];

  // ==========================================================================
  // link functions are outputs of the link, always driven
  // terminals 2 and 3 have no link function; their slots stay low and
  // their select is tied high, so these slots are never chosen
  wire logic [3:0] link_out;
  wire logic [3:0] link_oe;

  assign link_out = {2'b00, link_power_status_pin_i,
    bus_manager_contender_pin_i};
  assign link_oe = 4'h3;

  // ==========================================================================
  // terminals
  wire logic [3:0] pad_sync;
  wire logic [3:0] gp_level;
  fpgc_pkg::fpgc_pad_s pad [4];

  // one synchroniser for all four terminals; each bit settles alone
  fpgc_sync u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i(pin_in_i),
    .sync_o(pad_sync)
  );

  // terminal 0: contender or pin0
  // shared terminals fall back to the link whenever select is low
  fpgc_pin u_pin0 (
    .cfg_i(cfg[0]),
    .link_out_i(link_out[0]),
    .link_oe_i(link_oe[0]),
    .pad_sync_i(pad_sync[0]),
    .pad_o(pad[0]),
    .gp_level_o(gp_level[0])
  );

  // terminal 1: power status or pin1
  // stored pin1 bits wait unused until select is set
  fpgc_pin u_pin1 (
    .cfg_i(cfg[1]),
    .link_out_i(link_out[1]),
    .link_oe_i(link_oe[1]),
    .pad_sync_i(pad_sync[1]),
    .pad_o(pad[1]),
    .gp_level_o(gp_level[1])
  );

  // terminal 2, always pin2
  // link inputs are tied low and never reach the terminal
  fpgc_pin u_pin2 (
    .cfg_i(cfg[2]),
    .link_out_i(link_out[2]),
    .link_oe_i(link_oe[2]),
    .pad_sync_i(pad_sync[2]),
    .pad_o(pad[2]),
    .gp_level_o(gp_level[2])
  );

  // terminal 3, always pin3
  // driver stays off from reset until software enables it
  fpgc_pin u_pin3 (
    .cfg_i(cfg[3]),
    .link_out_i(link_out[3]),
    .link_oe_i(link_oe[3]),
    .pad_sync_i(pad_sync[3]),
    .pad_o(pad[3]),
    .gp_level_o(gp_level[3])
  );

  // enables and levels leave as plain vectors
  assign pin_out_o = {pad[3].out, pad[2].out, pad[1].out, pad[0].out};
  assign pin_oe_o = {pad[3].oe, pad[2].oe, pad[1].oe, pad[0].oe};

  // ==========================================================================
  // read path
  logic [31:0] rview;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  // a pin reads its terminal unless general-purpose logic drives it
  function automatic logic view_bit(
    input logic shows_level,
    input logic level,
    input logic stored
  );
    return shows_level ? level : stored;
  endfunction

  wire logic pin0_shows_level;
  wire logic pin1_shows_level;
  wire logic pin2_shows_level;
  wire logic pin3_shows_level;

  // data bits of undriven pins show the terminal level, inverted only on selected pins
  assign pin0_shows_level = !pin0_oe_bit || !sel0;
  assign pin1_shows_level = !pin1_oe_bit || !sel1;
  assign pin2_shows_level = !pin2_oe_bit;
  assign pin3_shows_level = !pin3_oe_bit;

  // only the data bits differ from the stored word
  always_comb begin
    rview = ctrl_r;
    rview[fpgc_pkg::FPGC_PIN0_DATA] = view_bit(pin0_shows_level,
      gp_level[0], pin0_data_bit);
    rview[fpgc_pkg::FPGC_PIN1_DATA] = view_bit(pin1_shows_level,
      gp_level[1], pin1_data_bit);
    rview[fpgc_pkg::FPGC_PIN2_DATA] = view_bit(pin2_shows_level,
      gp_level[2], pin2_data_bit);
    rview[fpgc_pkg::FPGC_PIN3_DATA] = view_bit(pin3_shows_level,
      gp_level[3], pin3_data_bit);
  end

  // unmapped addresses and idle cycles read zero, so the data stand
  // one cycle only
  assign rdata_nxt = rd_ctrl ? rview : 32'h00000000;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_r <= 32'h00000000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata_o = rdata_r;

endmodule // fpgc_top

`default_nettype wire

// File: test/fpgc_chk.sv
/* fpgc_chk: port assertions for fpgc_top.
   assumes: bound to the top instance, one clock domain. */
`timescale 1ns/1ns
`default_nettype none
module fpgc_chk (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic bus_manager_contender_pin_i,
  input wire logic link_power_status_pin_i,
  input wire logic [3:0] pin_in_i,
  input wire logic [3:0] pin_out_o,
  input wire logic [3:0] pin_oe_o
);
  // ==========================================================
  // shadow of the writable control bits
  logic [31:0] m_r;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      m_r <= 32'h00001010;
    else if (wr_i && addr_i == 8'hfc)
      m_r <= wdata_i & 32'h3131b1b1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // ==========================================================
  property p_lnk0;
    !m_r[7] |-> pin_oe_o[0] && pin_out_o[0] == bus_manager_contender_pin_i;
  endproperty
  a_lnk0: assert property (p_lnk0) else $error("terminal 0 link");
  property p_lnk1;
    !m_r[15] |-> pin_oe_o[1] && pin_out_o[1] == link_power_status_pin_i;
  endproperty
  a_lnk1: assert property (p_lnk1) else $error("terminal 1 link");
  property p_rsv;
    rd_i |=> (rdata_o & 32'hcece4e4e) == 32'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  property p_idle;
    (!rd_i || addr_i != 8'hfc) |=> rdata_o == 32'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("stray read data");
  property p_cfg;
    rd_i && addr_i == 8'hfc |=> (rdata_o & 32'h3030b0b0) == (m_r & 32'h3030b0b0);
  endproperty
  a_cfg: assert property (p_cfg) else $error("control readback");
  property p_pin3;
    pin_oe_o[3] == m_r[28] && (!m_r[28] || pin_out_o[3] == (m_r[24] ^ m_r[29]));
  endproperty
  a_pin3: assert property (p_pin3) else $error("pin 3 drive");
  property p_pin2;
    pin_oe_o[2] == m_r[20] && (!m_r[20] || pin_out_o[2] == (m_r[16] ^ m_r[21]));
  endproperty
  a_pin2: assert property (p_pin2) else $error("pin 2 drive");
  property p_pin1;
    m_r[15] |-> pin_oe_o[1] == m_r[12] && (!m_r[12] || pin_out_o[1] == (m_r[8] ^ m_r[13]));
  endproperty
  a_pin1: assert property (p_pin1) else $error("pin 1 drive");
  property p_pin0;
    m_r[7] |-> pin_oe_o[0] == m_r[4] && (!m_r[4] || pin_out_o[0] == (m_r[0] ^ m_r[5]));
  endproperty
  a_pin0: assert property (p_pin0) else $error("pin 0 drive");
  c_gp0: cover property (m_r[7] && m_r[4]);
  c_rd: cover property (rd_i && addr_i == 8'hfc);
  c_miss: cover property (wr_i && addr_i != 8'hfc);
endmodule // fpgc_chk
`default_nettype wire

// File: test/fpgc_pads.sv
/* fpgc_pads: the four board terminals.
   assumes: an outside driver per terminal; pull-up when nobody drives. */
`timescale 1ns/1ns
`default_nettype none
module fpgc_pads (
  input wire logic [3:0] out_i,
  input wire logic [3:0] oe_i,
  input wire logic [3:0] ext_i,
  input wire logic [3:0] ext_en_i,
  output logic [3:0] lvl_o
);
  // undriven terminals float up, never to the last value
  assign lvl_o = (oe_i & out_i) | (~oe_i & ((ext_en_i & ext_i) | ~ext_en_i));
endmodule // fpgc_pads
`default_nettype wire

// File: test/fpgc_tb_top.sv
/* fpgc_tb_top: directed bench for fpgc_top.
   assumes: fpgc_pads closes the terminal loop. */
`timescale 1ns/1ns
`default_nettype none
module fpgc_tb_top;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, bus_manager_contender_pin = 1'b1, link_power_status_pin = 1'b0;
  logic [7:0] addr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] pin_in, pout, poe, ext = 4'h0, ext_en = 4'h0;
  int fail_count = 0, comparisons = 0;
  always #10 clk = ~clk;
  fpgc_top dut_u (.clk_i(clk), .rst_n_i(rst_n), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .bus_manager_contender_pin_i(bus_manager_contender_pin), .link_power_status_pin_i(link_power_status_pin),
    .pin_in_i(pin_in), .pin_out_o(pout), .pin_oe_o(poe));
  fpgc_pads pads_u (.out_i(pout), .oe_i(poe), .ext_i(ext),
    .ext_en_i(ext_en), .lvl_o(pin_in));
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp4(input logic [3:0] got, input logic [3:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 cmp32(rdata, exp);
  endtask
  task automatic tally_and_finish;
    if (fail_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset;
    cmp4(poe, 4'b0011);
    cmp4({2'b00, pout[1:0]}, {2'b00, link_power_status_pin, bus_manager_contender_pin});
    rd_reg(8'hfc, 32'h01011011);
  endtask
  task automatic t_reserved;
    wr_reg(8'hfc, 32'hffffffff);
    cmp4(poe, 4'hf);
    cmp4(pout, 4'h0);
    rd_reg(8'hfc, 32'h3131b1b1);
    wr_reg(8'hfc, 32'h11119191);
    cmp4(pout, 4'hf);
    wr_reg(8'hf8, 32'h0);
    rd_reg(8'hfc, 32'h11119191);
    rd_reg(8'hf8, 32'h0);
  endtask
  task automatic t_input;
    @(posedge clk);
    ext <= 4'b0101;
    ext_en <= 4'hf;
    wr_reg(8'hfc, 32'h2020a0a0);
    cmp4(poe, 4'h0);
    // two-flop synchroniser needs two edges
    repeat (3) @(posedge clk);
    rd_reg(8'hfc, 32'h2120a1a0);
  endtask
  task automatic t_link;
    wr_reg(8'hfc, 32'h00003131);
    @(posedge clk);
    bus_manager_contender_pin <= 1'b0;
    link_power_status_pin <= 1'b1;
    @(posedge clk);
    #1 cmp4(pout, 4'b0010);
    cmp4(poe, 4'b0011);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    t_reset();
    t_reserved();
    t_input();
    t_link();
    tally_and_finish();
  end
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    tally_and_finish();
  end
endmodule // fpgc_tb_top
bind fpgc_top fpgc_chk chk_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .pin_in_i(pin_in_i), .pin_out_o(pin_out_o),
  .bus_manager_contender_pin_i(bus_manager_contender_pin_i),
  .link_power_status_pin_i(link_power_status_pin_i), .pin_oe_o(pin_oe_o));
`default_nettype wire
